/* logic/dicc_top.v */
// Input capture and core update for a 14-bit current-steering converter.
// Assumes data pairs, sample clock pair and static pins arrive asynchronously.
`timescale 1ns/1ps
`include "dicc_defs.vh"

module dicc_top #(
	parameter W        = `DICC_DW,
	parameter PD_ENTRY = `DICC_PD_ENTRY_CYC,
	parameter PD_EXIT  = `DICC_PD_EXIT_CYC
) (
	input  wire         mclk,                        // System clock, 50 MHz
	input  wire         arst_n,                      // Async reset, active low
	input  wire [W-1:0] data_pos,                    // Positive data lines
	input  wire [W-1:0] data_neg,                    // Negative data lines
	input  wire         sample_clock_positive,       // Sample clock, sampled
	input  wire         sample_clock_negative,       // Complementary clock
	input  wire         loop_disable_input,          // High turns loop off
	input  wire         sleep_input,                 // Power-down, high active
	input  wire         bias_valid,                  // Bias code presented
	input  wire [9:0]   bias_code,                   // Bias current, units
	output reg  [W-1:0] core_code_r,                 // Word in converter core
	output reg  [W-1:0] primary_current_output,      // Primary current, LSBs
	output reg  [W-1:0] complementary_current_output,// Complement current
	output reg  [13:0]  full_scale_r,                // Full scale, bias units
	output reg          loop_enabled_r,              // Alignment loop running
	output reg          powered_r,                   // Output current active
	output reg          overrun_r                    // Word lost to stall
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg [W-1:0] dp_s1_r, dp_s2_r, dn_s1_r, dn_s2_r;
	reg [1:0]   ck_s1_r, ck_s2_r;
	reg         ld_s1_r, ld_s2_r, sl_s1_r, sl_s2_r;
	reg         ck_prev_r;
	reg [W-1:0] cap_r;
	reg         cap_v_r;
	reg [1:0]   st_r;
	reg [21:0]  tmr_r;
	reg [1:0]   st_nxt;
	reg [21:0]  tmr_nxt;
	wire        ck_diff;
	wire        rise;
	wire [W-1:0] word;
	wire        b_in_ready;
	wire        b_out_valid;
	wire [W-1:0] b_out_data;

	// Two stages on every pin except bias_valid and bias_code before any logic looks at it
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dp_s1_r <= {W{1'b0}};
			dp_s2_r <= {W{1'b0}};
			dn_s1_r <= {W{1'b1}};
			dn_s2_r <= {W{1'b1}};
			ck_s1_r <= 2'h2;
			ck_s2_r <= 2'h2;
			ld_s1_r <= 1'b1;
			ld_s2_r <= 1'b1;
			sl_s1_r <= 1'b1;
			sl_s2_r <= 1'b1;
		end else begin
			dp_s1_r <= data_pos;
			dp_s2_r <= dp_s1_r;
			dn_s1_r <= data_neg;
			dn_s2_r <= dn_s1_r;
			ck_s1_r <= {sample_clock_negative, sample_clock_positive};
			ck_s2_r <= ck_s1_r;
			ld_s1_r <= loop_disable_input;
			ld_s2_r <= ld_s1_r;
			sl_s1_r <= sleep_input; // Async pin, resynchronised
			sl_s2_r <= sl_s1_r;
		end
	end

	// ----------------------------------------
	// Differential decode
	// ----------------------------------------
	// Positive above negative reads as one; equal lines read as zero
	function dif_bit;
		input p;
		input n;
		begin
			dif_bit = p & ~n;
		end
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
			assign word[gi] = dif_bit(dp_s2_r[gi], dn_s2_r[gi]);
		end
	endgenerate

	assign ck_diff = dif_bit(ck_s2_r[0], ck_s2_r[1]);
	assign rise    = ck_diff & ~ck_prev_r;

	// ----------------------------------------
	// Capture stage
	// ----------------------------------------
	// Loop state is not consulted here, so latency never depends on it
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ck_prev_r <= 1'b0;
			cap_r     <= {W{1'b0}};
			cap_v_r   <= 1'b0;
			overrun_r <= 1'b0;
		end else begin
			ck_prev_r <= ck_diff;
			cap_v_r   <= 1'b0;
			if (rise) begin
				cap_r   <= word;
				cap_v_r <= 1'b1;
			end
			if (cap_v_r & ~b_in_ready) begin
				overrun_r <= 1'b1;
			end
		end
	end

	// Buffer lets the core stall without losing the captured word
	dicc_buf #(
		.W(W)
	) u_buf (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.in_valid  (cap_v_r),
		.in_ready  (b_in_ready),
		.in_data   (cap_r),
		.out_valid (b_out_valid),
		.out_ready (rise),
		.out_data  (b_out_data)
	);

	// ----------------------------------------
	// Core update and output currents
	// ----------------------------------------
	// Core loads only on the following sample edge and holds otherwise
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			core_code_r <= {W{1'b0}};
		end else if (rise & b_out_valid) begin
			core_code_r <= b_out_data;
		end
	end

	// Currents in LSB units of full scale over 16384
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			primary_current_output       <= {W{1'b0}};
			complementary_current_output <= {W{1'b0}};
		end else if (!powered_r) begin
			primary_current_output       <= {W{1'b0}};
			complementary_current_output <= {W{1'b0}};
		end else begin
			primary_current_output       <= core_code_r;
			complementary_current_output <= `DICC_CODE_MAX - core_code_r;
		end
	end

	// Full scale tracks bias with a gain of sixteen
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			full_scale_r <= 14'h0000;
		end else if (bias_valid) begin
			full_scale_r <= {bias_code, 4'h0};
		end
	end

	// Loop status; affects nothing on the data path
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			loop_enabled_r <= 1'b0;
		end else begin
			loop_enabled_r <= ~ld_s2_r;
		end
	end

	// ----------------------------------------
	// Power state machine
	// ----------------------------------------
	always @* begin
		st_nxt  = st_r;
		tmr_nxt = tmr_r;
		case (st_r)
		`DICC_ST_RUN: begin
			if (sl_s2_r) begin
				st_nxt  = `DICC_ST_ENTER;
				tmr_nxt = 22'd0;
			end
		end
		`DICC_ST_ENTER: begin
			if (!sl_s2_r) begin
				st_nxt = `DICC_ST_RUN;
			end else if (tmr_r >= PD_ENTRY - 1) begin
				st_nxt = `DICC_ST_SLEEP;
			end else begin
				tmr_nxt = tmr_r + 22'd1;
			end
		end
		`DICC_ST_SLEEP: begin
			if (!sl_s2_r) begin
				st_nxt  = `DICC_ST_WAKE;
				tmr_nxt = 22'd0;
			end
		end
		`DICC_ST_WAKE: begin
			if (sl_s2_r) begin
				st_nxt = `DICC_ST_SLEEP;
			end else if (tmr_r >= PD_EXIT - 1) begin
				st_nxt = `DICC_ST_RUN;
			end else begin
				tmr_nxt = tmr_r + 22'd1;
			end
		end
		default: begin
			st_nxt = `DICC_ST_SLEEP;
		end
		endcase
	end

	// Output is cut at once on request; entry time bounds the full sleep
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_r      <= `DICC_ST_SLEEP;
			tmr_r     <= 22'd0;
			powered_r <= 1'b0;
		end else begin
			st_r      <= st_nxt;
			tmr_r     <= tmr_nxt;
			powered_r <= (st_nxt == `DICC_ST_RUN) & ~sl_s2_r;
		end
	end
endmodule

/* logic/dicc_defs.vh */
// Constants for the converter input capture front end.
// Assumes a 50 MHz system clock; included by dicc_top.v and dicc_buf.v.
`ifndef DICC_DEFS_VH
`define DICC_DEFS_VH

// ----------------------------------------
// Data word
// ----------------------------------------
`define DICC_DW            14
`define DICC_CODE_MAX      14'h3fff
`define DICC_CODE_SPAN     15'h4000
`define DICC_BIAS_GAIN     5'h10

// ----------------------------------------
// Timing
// ----------------------------------------
`define DICC_CLK_MHZ       50
`define DICC_PD_ENTRY_NS   5000
`define DICC_PD_EXIT_US    3000
`define DICC_PD_ENTRY_CYC  ((`DICC_PD_ENTRY_NS * `DICC_CLK_MHZ) / 1000)
`define DICC_PD_EXIT_CYC   (`DICC_PD_EXIT_US * `DICC_CLK_MHZ)

// ----------------------------------------
// Power states
// ----------------------------------------
`define DICC_ST_RUN        2'h0
`define DICC_ST_ENTER      2'h1
`define DICC_ST_SLEEP      2'h2
`define DICC_ST_WAKE       2'h3

`endif

/* logic/dicc_buf.v */
// Two-entry valid/ready buffer for captured words.
// Assumes one clock domain; source and sink both on mclk.
`timescale 1ns/1ps
`include "dicc_defs.vh"

module dicc_buf #(
	parameter W = `DICC_DW
) (
	input  wire         mclk,     // System clock
	input  wire         arst_n,   // Async reset, active low
	input  wire         in_valid, // Word offered
	output wire         in_ready, // Room for a word
	input  wire [W-1:0] in_data,  // Offered word
	output wire         out_valid,// Word held
	input  wire         out_ready,// Sink accepts
	output wire [W-1:0] out_data  // Oldest word
);
	reg [W-1:0] mem_r [0:1];
	reg         wp_r;
	reg         rp_r;
	reg [1:0]   cnt_r;
	wire        push;
	wire        pop;

	// ----------------------------------------
	// Handshakes
	// ----------------------------------------
	assign in_ready  = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data  = mem_r[rp_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage written without reset; only counted entries are seen
	always @(posedge mclk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end

	// Pointers and fill count
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wp_r  <= 1'b0;
			rp_r  <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			if (push) begin
				wp_r <= ~wp_r;
			end
			if (pop) begin
				rp_r <= ~rp_r;
			end
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

/* test/dicc_top_sva.sv */
// Port checker for the capture front end.
// Assumes it is bound onto dicc_top.
`timescale 1ns/1ps
module dicc_top_sva #(
	parameter W        = 14,
	parameter PD_ENTRY = 250,
	parameter PD_EXIT  = 150000
) (
	input wire logic         mclk,                         // Clock
	input wire logic         arst_n,                       // Reset
	input wire logic         sample_clock_positive,        // Sample
	input wire logic         sample_clock_negative,        // Sample
	input wire logic         loop_disable_input,           // Loop
	input wire logic         sleep_input,                  // Sleep
	input wire logic         bias_valid,                   // Load
	input wire logic [9:0]   bias_code,                    // Bias
	input wire logic [W-1:0] core_code_r,                  // Core
	input wire logic [W-1:0] primary_current_output,       // Out
	input wire logic [W-1:0] complementary_current_output, // Out
	input wire logic [13:0]  full_scale_r,                 // Scale
	input wire logic         loop_enabled_r,               // Loop
	input wire logic         powered_r                     // Power
);
	default clocking @(posedge mclk); endclocking
	wire        diff_w = sample_clock_positive & ~sample_clock_negative;
	logic       diff_q;
	logic [3:0] since_r;
	logic [1:0] up_r;
	int         low_r;
	// Checks rest for three edges after reset, while pin synchronisers still hold reset levels
	default disable iff (!arst_n || up_r != 2'h3);
	// Saturating counts, so long idle spells never wrap into false passes
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			diff_q <= 1'b0;
			since_r <= 4'hf;
			up_r <= 2'h0;
			low_r <= 0;
		end else begin
			diff_q <= diff_w;
			up_r <= up_r + {1'b0, up_r != 2'h3};
			since_r <= (diff_w && !diff_q) ? 4'h0 : since_r + {3'h0, since_r != 4'hf};
			low_r <= sleep_input ? 0 : low_r + int'(low_r < PD_EXIT + 8);
		end
	end
	sequence s_on; powered_r ##1 powered_r; endsequence
	sequence s_off; !powered_r ##1 !powered_r; endsequence
	sequence s_bias_load; $rose(bias_valid) ##1 $stable(bias_code); endsequence
	a_curr_sum: assert property (s_on |-> primary_current_output + complementary_current_output == 14'h3fff)
		else $error("currents do not sum to full scale");
	a_sleep_zero: assert property (s_off |-> primary_current_output == '0 && complementary_current_output == '0)
		else $error("current while powered down");
	a_sleep_off: assert property ($rose(sleep_input) |-> ##[0:4] primary_current_output == '0)
		else $error("sleep did not switch current off");
	a_wake_time: assert property ($rose(powered_r) |-> low_r >= PD_EXIT - 1)
		else $error("wake too early");
	a_loop_off: assert property (loop_disable_input [*4] |-> !loop_enabled_r)
		else $error("loop running while disabled");
	a_loop_on: assert property (!loop_disable_input [*4] |-> loop_enabled_r)
		else $error("loop stopped while enabled");
	a_core_hold: assert property ($changed(core_code_r) |-> since_r <= 4'h6)
		else $error("core changed without sample edge");
	a_bias_gain: assert property (s_bias_load |-> ##[0:3] full_scale_r == {bias_code, 4'h0})
		else $error("full scale not sixteen times bias");
endmodule
bind dicc_top dicc_top_sva #(.W(W), .PD_ENTRY(PD_ENTRY), .PD_EXIT(PD_EXIT)) sva_u (
	.mclk(mclk), .arst_n(arst_n), .sample_clock_positive(sample_clock_positive),
	.sample_clock_negative(sample_clock_negative), .loop_disable_input(loop_disable_input),
	.sleep_input(sleep_input), .bias_valid(bias_valid), .bias_code(bias_code), .core_code_r(core_code_r),
	.primary_current_output(primary_current_output), .complementary_current_output(complementary_current_output),
	.full_scale_r(full_scale_r), .loop_enabled_r(loop_enabled_r), .powered_r(powered_r));

/* test/dicc_source.sv */
// Data source model: one word per sample period.
// Assumes the bench calls send.
`timescale 1ns/1ps
module dicc_source (
	input  wire logic   mclk,     // Clock
	output logic [13:0] data_pos, // Lines
	output logic [13:0] data_neg, // Lines
	output logic        clk_p,    // Sample
	output logic        clk_n     // Sample
);
	initial begin
		data_pos = 14'h0000;
		data_neg = 14'h3fff;
		clk_p = 1'b0;
		clk_n = 1'b1;
	end
	// Fixed nine-cycle period; lines flip once hold has run out
	task send(input logic [13:0] w);
		@(posedge mclk);
		data_pos <= w;
		data_neg <= ~w;
		clk_p <= 1'b1;
		clk_n <= 1'b0;
		repeat (4) @(posedge mclk);
		clk_p <= 1'b0;
		clk_n <= 1'b1;
		repeat (2) @(posedge mclk);
		data_pos <= ~w;
		data_neg <= w;
		repeat (2) @(posedge mclk);
	endtask
endmodule

/* test/dicc_top_bench.sv */
// Bench: source model, reference of one-word latency.
// Assumes the checker binds itself.
`timescale 1ns/1ps
module dicc_top_bench;
	localparam PD_EXIT = 10;
	logic        mclk, arst_n, loop_d, sleep_in, bias_v;
	logic [9:0]  bias_c;
	logic [31:0] seed;
	logic [13:0] w;
	int          model_q[$];
	wire  [13:0] dp, dn, core, prim, comp, fs;
	wire         cp, cn, loop_en, powered, overrun;
	int          err_total, total_checks, n, code;
	dicc_source src_u (.mclk(mclk), .data_pos(dp), .data_neg(dn), .clk_p(cp), .clk_n(cn));
	dicc_top #(.PD_ENTRY(4), .PD_EXIT(PD_EXIT)) dut_u (
		.mclk(mclk), .arst_n(arst_n), .data_pos(dp), .data_neg(dn),
		.sample_clock_positive(cp), .sample_clock_negative(cn),
		.loop_disable_input(loop_d), .sleep_input(sleep_in), .bias_valid(bias_v),
		.bias_code(bias_c), .core_code_r(core), .primary_current_output(prim),
		.complementary_current_output(comp), .full_scale_r(fs),
		.loop_enabled_r(loop_en), .powered_r(powered), .overrun_r(overrun));
	always #10 mclk = ~mclk;
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task chk(input logic [13:0] got, input logic [13:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task complete_run();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Reference queue: core shows the word sent one period earlier
	task step(input logic [13:0] v, input logic on);
		src_u.send(v);
		model_q.push_back(v);
		code = model_q.pop_front();
		#1;
		chk(core, 14'(code));
		chk(prim, on ? 14'(code) : 14'h0000);
		chk(comp, on ? 14'(16383 - code) : 14'h0000);
		chk({13'h0, powered}, {13'h0, on});
	endtask
	// Bounded wait for output current to come up
	task wait_on();
		n = 0;
		while (powered !== 1'b1 && n < 500) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 500) begin
			err_total++;
			$display("ERROR %0t: no power-up", $time);
			complete_run();
		end
	endtask
	initial begin
		mclk = 0;
		arst_n = 0;
		loop_d = 0;
		sleep_in = 0;
		bias_v = 0;
		bias_c = 0;
		err_total = 0;
		total_checks = 0;
		seed = 67;
		model_q.push_back(0);
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		wait_on();
		// Code extremes, then random words; slow rate, either loop state
		for (int i = 0; i < 12; i++) begin
			w = (i == 0) ? 14'h3fff : (i == 1) ? 14'h0000 : 14'(rnd());
			@(posedge mclk);
			loop_d <= i[2];
			step(w, 1'b1);
			chk({13'h0, loop_en}, {13'h0, ~i[2]});
		end
		for (int i = 0; i < 3; i++) begin
			@(posedge mclk);
			bias_c <= (i == 0) ? 10'h3ff : (i == 1) ? 10'h001 : 10'(rnd());
			bias_v <= 1'b1;
			@(posedge mclk);
			bias_v <= 1'b0;
			repeat (5) @(posedge mclk);
			#1;
			chk(fs, {bias_c, 4'h0});
		end
		// Power-down mid-stream: capture continues, currents read zero
		@(posedge mclk);
		sleep_in <= 1'b1;
		step(14'h1555, 1'b0);
		step(14'h2aaa, 1'b0);
		@(posedge mclk);
		sleep_in <= 1'b0;
		wait_on();
		// Wake: two sync stages, one edge to enter the wake state, the wake count
		chk(14'(n >= PD_EXIT && n <= PD_EXIT + 6), 14'h0001);
		step(14'(rnd()), 1'b1);
		chk({13'h0, overrun}, 14'h0000);
		// Reset in mid-run, then LSB and MSB positions through the core
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk(prim, 14'h0000);
		chk(core, 14'h0000);
		@(posedge mclk);
		arst_n <= 1'b1;
		model_q.delete();
		model_q.push_back(0);
		wait_on();
		step(14'h0001, 1'b1);
		step(14'h2000, 1'b1);
		step(14'h0000, 1'b1);
		complete_run();
	end
endmodule
